// ---- dv/sepr_props.sv ----
// checker of the two-wire link between the eeprom end and the master end
`timescale 1ns/10ps
module sepr_props (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // link signals
  input wire logic scl,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  logic [7:0] cyc;

  // cycles since reset release, saturating so it never wraps back
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cyc <= 8'h00;
    end else if (cyc != 8'hff) begin
      cyc <= cyc + 8'h01;
    end
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // line conditions built from clock and data
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_host_start;
    scl && $past(scl) && $rose(sda_host_oe);
  endsequence

  // both ends only ever pull low, never drive high
  a_open_drain_only: assert property (!sda_dev_out && !sda_host_out)
    else $error("an end drives the data line high");
  // device data must not move while the clock is high
  a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device data changed while clock high");
  a_dev_drive_late: assert property ($changed(sda_dev_oe) |-> $past(scl, 2) == 1'b0)
    else $error("device data changed too soon after clock fall");
  a_dev_bit_hold: assert property ($changed(sda_dev_oe) |=> $stable(sda_dev_oe) [*8])
    else $error("device data bit too short");
  // master never starts over a driving device
  a_start_free: assert property (s_host_start |-> !$past(sda_dev_oe))
    else $error("start issued while device drives");
  // after a stop the device stays off the line
  a_stop_quiet: assert property (s_stop |=> !sda_dev_oe [*8])
    else $error("device drives after stop");
  // deaf during power-on initialisation
  a_init_deaf: assert property (cyc < 8'h64 |-> !sda_dev_oe)
    else $error("device answered during initialisation");
  // clock phases last at least eight cycles
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
endmodule // sepr_props

// ---- dv/sepr_tb_top.sv ----
// self-checking bench joining both ends of the eeprom link
`timescale 1ns/10ps
module sepr_tb_top import sepr_pkg::*;;
  logic clock = 1'h0;
  logic rst_n;
  logic cmd_valid;
  logic [1:0] cmd_op;
  logic [2:0] cmd_sel;
  logic [7:0] cmd_waddr;
  logic [7:0] cmd_len;
  logic rd_ready;
  logic cmd_ready;
  logic no_ack;
  logic rd_valid;
  logic busy;
  logic [7:0] rd_data;
  logic [7:0] addr_ptr;
  logic [7:0] got[$];
  int bad_count = 0;
  int n_checks = 0;
  int n;

  sepr_if i_sepr_if ();
  sepr_dev i_sepr_dev (.CLOCK(clock), .RST_N(rst_n), .BUS(i_sepr_if.dev), .DEV_SEL(3'h5),
    .LOW_VCC(1'h0), .BUSY(busy), .ADDR_PTR(addr_ptr));
  sepr_host i_sepr_host (.CLOCK(clock), .RST_N(rst_n), .BUS(i_sepr_if.host),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_SEL(cmd_sel), .CMD_WADDR(cmd_waddr),
    .CMD_LEN(cmd_len), .CMD_READY(cmd_ready), .NO_ACK(no_ack), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .RD_READY(rd_ready));
  sepr_props i_sepr_props (.CLOCK(clock), .RST_N(rst_n), .scl(i_sepr_if.scl),
    .sda_host_out(i_sepr_if.sda_host_out), .sda_host_oe(i_sepr_if.sda_host_oe),
    .sda_dev_out(i_sepr_if.sda_dev_out), .sda_dev_oe(i_sepr_if.sda_dev_oe),
    .sda(i_sepr_if.sda));

  // 50 mhz clock
  always #10 clock = ~clock;

  // collect every byte popped from the read buffer
  always @(posedge clock) begin
    if (rd_valid === 1'h1 && rd_ready === 1'h1) got.push_back(rd_data);
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hold the command until taken, then wait for the master to finish
  task automatic do_cmd(input sepr_op_t op, input logic [2:0] sel, input logic [7:0] wa,
    input logic [7:0] len);
    int k;
    cmd_op = op;
    cmd_sel = sel;
    cmd_waddr = wa;
    cmd_len = len;
    cmd_valid = 1'h1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (cmd_ready !== 1'h1 && k < 100);
    #1 cmd_valid = 1'h0;
    k = 0;
    while (cmd_ready !== 1'h1 && k < 40000) begin
      @(posedge clock);
      k++;
    end
    #1;
    check({7'h00, k < 40000}, 8'h01);
  endtask

  // memory is never written here, so every byte read back is zero
  task automatic check_bytes(input int cnt);
    check(8'(got.size()), 8'(cnt));
    foreach (got[i]) check(got[i], 8'h00);
    got.delete();
  endtask

  initial begin
    rst_n = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = OP_CUR;
    cmd_sel = 3'h5;
    cmd_waddr = 8'h00;
    cmd_len = 8'h01;
    rd_ready = 1'h1;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'h1;
    check(busy, 8'h01);
    check(addr_ptr, 8'h00);
    n = 0;
    while (busy !== 1'h0 && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check({7'h00, n >= 99 && n < 1000}, 8'h01);
    // random read across the top of the array
    do_cmd(OP_RAND, 3'h5, 8'hfe, 8'h03);
    check(no_ack, 8'h00);
    check_bytes(3);
    check(addr_ptr, 8'h01);
    // current read right after, back to back
    do_cmd(OP_CUR, 3'h5, 8'h00, 8'h02);
    check_bytes(2);
    check(addr_ptr, 8'h03);
    // wrong straps: no acknowledge, pointer untouched
    do_cmd(OP_RAND, 3'h2, 8'h40, 8'h01);
    check(no_ack, 8'h01);
    check_bytes(0);
    check(addr_ptr, 8'h03);
    // stuck-bus recovery, then a normal read
    do_cmd(OP_REC, 3'h5, 8'h00, 8'h01);
    check(no_ack, 8'h00);
    do_cmd(OP_RAND, 3'h5, 8'h7f, 8'h02);
    check(no_ack, 8'h00);
    check_bytes(2);
    check(addr_ptr, 8'h81);
    // receiver stalls: both buffer entries fill, master waits, no byte lost
    rd_ready = 1'h0;
    fork
      do_cmd(OP_RAND, 3'h5, 8'h1e, 8'h04);
      begin
        repeat (4000) @(posedge clock);
        #1;
        check(rd_valid, 8'h01);
        check(cmd_ready, 8'h00);
        rd_ready = 1'h1;
      end
    join
    check_bytes(4);
    check(addr_ptr, 8'h22);
    do_cmd(OP_CUR, 3'h5, 8'h00, 8'h01);
    check_bytes(1);
    check(addr_ptr, 8'h23);
    stop_test();
  end

  // cut a hang short well beyond the expected run length
  initial begin
    #1000000;
    bad_count++;
    stop_test();
  end
endmodule // sepr_tb_top

// ---- rtl/sepr_cfg.svh ----
// named constants for the serial eeprom read path and its bus master
`ifndef SEPR_CFG_SVH
`define SEPR_CFG_SVH
// device type code in the upper address bits
`define SEPR_DEV_CODE 4'ha
// power-on initialisation and internal write cycle lengths, in clock cycles
`define SEPR_INIT_CYC 16'h0064
`define SEPR_WR_CYC 16'h03e8
// master bus timing: one quarter of an scl period is this count plus one
`define SEPR_QTR_LAST 8'h09
// bit counts within a byte slot
`define SEPR_BYTE_BITS 4'h8
`define SEPR_LAST_DATA 4'h7
`define SEPR_DUMMY_LAST 4'h8
`define SEPR_STOP_CNT 4'h1
`define SEPR_FIRST_BIT 4'h1
// word address split: bits at and above the page low bit stay during writes
`define SEPR_WORD_ADDR_TOP_BIT 7
`define SEPR_WORD_ADDR_PAGE_LOW_BIT 4
`define SEPR_PAGE_STEP 4'h1
`define SEPR_ADDR_STEP 8'h01
// synchroniser vector layout in the device
`define SEPR_SY_SCL 0
`define SEPR_SY_SDA 1
`define SEPR_SY_SEL_LO 2
`define SEPR_SY_SEL_HI 4
`define SEPR_SY_LVC 5
// storage and pin constants
`define SEPR_MEM_INIT 8'h00
`define SEPR_LOW 1'b0
`define SEPR_LEN_LAST 8'h01
`define SEPR_LEN_STEP 8'h01
`define SEPR_TMR_STEP 16'h0001
`define SEPR_DIV_STEP 8'h01
`define SEPR_CNT_STEP 4'h1
`define SEPR_SEQ_STEP 3'h1
`define SEPR_Q_LAST 2'h3
`define SEPR_Q_STEP 2'h1
`endif

// ---- rtl/sepr_dev.sv ----
// eeprom end: address decode, reads, pointer handling, bus housekeeping
//
// What this block does
// - pointer keeps last accessed location plus one across transfers
// - ack read address, then shift out word
// - pointer steps after eighth data bit out
// - writes advance only low word address bits
// - master nack plus stop ends read, releases
// - dummy write loads word address into pointer
// - master repeats start with read address next
// - master ack makes device send next byte
// - read pointer wraps from top to bottom
// - master may continue straight after poll ack
// - master never starts while device drives data
// - start then stop resets serial interface
// - recovery: start, nine high clocks, start, stop
// - high sda during clocks releases device output
// - master follows nine clocks with start
// - ignore bus during initialisation, then standby
// - low supply at stop cancels pending write
// - master checks acknowledge after every byte it sends
// - master runs recovery only when given an OP_REC command
// - no address ack while write cycle runs
// - write only after data byte, ack, stop
`timescale 1ns/10ps
`include "sepr_cfg.svh"
module sepr_dev import sepr_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // two-wire bus
  sepr_if.dev BUS,
  // address straps and supply monitor pins
  input wire logic [2:0] DEV_SEL,
  input wire logic LOW_VCC,
  // status
  output logic BUSY,
  output logic [7:0] ADDR_PTR
);
  sepr_dev_t r;
  sepr_dev_t n;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] rd_word;

  // edge and condition detection on the synchronised pins
  always_comb begin
    scl = r.s2[`SEPR_SY_SCL];
    sda = r.s2[`SEPR_SY_SDA];
    rise = scl & ~r.s3_scl;
    fall = ~scl & r.s3_scl;
    start = scl & r.s3_scl & ~sda & r.s3_sda;
    stop = scl & r.s3_scl & sda & ~r.s3_sda;
    rd_word = r.mem[r.ptr];
  end

  // next state of the whole device
  always_comb begin
    n = r;
    n.s1 = {LOW_VCC, DEV_SEL, BUS.sda, BUS.scl};
    n.s2 = r.s1;
    n.s3_scl = r.s2[`SEPR_SY_SCL];
    n.s3_sda = r.s2[`SEPR_SY_SDA];
    if (r.st == DS_INIT || r.st == DS_BUSY) begin
      // deaf to the bus until the timer runs out
      n.oe = 1'b0;
      if (r.tmr == 16'h0000) begin
        n.st = DS_IDLE; // standby
      end else begin
        n.tmr = r.tmr - `SEPR_TMR_STEP;
      end
    end else if (start) begin
      // a start outside initialisation and the write cycle abandons the current command, pointer kept
      n.st = DS_RX;
      n.kind = BK_DEV;
      n.cnt = 4'h0;
      n.oe = 1'b0;
      n.pend = 1'b0;
    end else if (stop) begin
      n.oe = 1'b0; // release the line
      n.pend = 1'b0;
      n.st = DS_IDLE;
      // only a stop right after a data ack commits
      if (r.pend && r.st == DS_RX && r.kind == BK_DATA && r.cnt == `SEPR_STOP_CNT) begin
        if (!r.s2[`SEPR_SY_LVC]) begin
          n.mem[r.pend_addr] = r.pend_data;
          n.st = DS_BUSY;
          n.tmr = `SEPR_WR_CYC;
        end // low supply: the write is dropped
      end
    end else begin
      unique case (r.st)
        DS_INIT, DS_BUSY, DS_IDLE, DS_WAIT: begin
          n.oe = 1'b0;
        end
        DS_RX: begin
          if (rise) begin
            n.sh = {r.sh[6:0], sda};
            n.cnt = r.cnt + `SEPR_CNT_STEP;
          end else if (fall && r.cnt == `SEPR_BYTE_BITS) begin
            unique case (r.kind)
              BK_DEV: begin
                // answer only our own type code and strap value
                if (r.sh[7:1] == {`SEPR_DEV_CODE, r.s2[`SEPR_SY_SEL_HI:`SEPR_SY_SEL_LO]}) begin
                  n.rw = r.sh[0];
                  n.oe = 1'b1;
                  n.st = DS_ACK;
                end else begin
                  n.st = DS_WAIT;
                end
              end
              BK_WORD: begin
                n.ptr = r.sh; // dummy write loads the pointer
                n.oe = 1'b1;
                n.st = DS_ACK;
              end
              BK_DATA: begin
                // hold one byte until the stop decides its fate
                n.pend_addr = r.ptr;
                n.pend_data = r.sh;
                n.pend = 1'b1;
                n.ptr[`SEPR_WORD_ADDR_PAGE_LOW_BIT-1:0] =
                  r.ptr[`SEPR_WORD_ADDR_PAGE_LOW_BIT-1:0] + `SEPR_PAGE_STEP;
                n.oe = 1'b1;
                n.st = DS_ACK;
              end
              default: begin
                n.st = DS_WAIT;
              end
            endcase
          end
        end
        DS_ACK: begin
          // the ack slot ends on the falling scl edge
          if (fall) begin
            n.oe = 1'b0;
            n.cnt = 4'h0;
            if (r.kind == BK_DEV && r.rw) begin
              // first bit of the word at the pointer goes out at once
              n.sh = rd_word;
              n.oe = ~rd_word[7];
              n.cnt = `SEPR_FIRST_BIT;
              n.st = DS_TX;
            end else begin
              n.kind = (r.kind == BK_DEV) ? BK_WORD : BK_DATA;
              n.st = DS_RX;
            end
          end
        end
        DS_TX: begin
          if (fall) begin
            if (r.cnt == `SEPR_BYTE_BITS) begin
              // eighth bit done: step and wrap the pointer
              n.ptr = r.ptr + `SEPR_ADDR_STEP;
              n.oe = 1'b0;
              n.st = DS_MACK;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.oe = ~r.sh[6];
              n.cnt = r.cnt + `SEPR_CNT_STEP;
            end
          end
        end
        DS_MACK: begin
          if (rise) begin
            // high sda means nack: stay released until stop or start
            n.st = sda ? DS_WAIT : DS_ACK; // ack asks for the next byte
          end
        end
        default: begin
          n.st = DS_IDLE;
        end
      endcase
    end
  end

  // one register for all state; memory content survives bus resets
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      r <= '0;
      r.s1 <= 6'h03;
      r.s2 <= 6'h03;
      r.s3_scl <= 1'b1;
      r.s3_sda <= 1'b1;
      r.st <= DS_INIT;
      r.kind <= BK_DEV;
      r.tmr <= `SEPR_INIT_CYC;
      r.mem <= {256{`SEPR_MEM_INIT}};
    end else begin
      r <= n;
    end
  end

  assign BUS.sda_dev_oe = r.oe;
  assign BUS.sda_dev_out = `SEPR_LOW;
  assign BUSY = r.st[7] | r.st[0]; // write cycle or initialisation
  assign ADDR_PTR = r.ptr;
endmodule // sepr_dev

// ---- rtl/sepr_host.sv ----
// master end: current and random reads, stuck-bus recovery, read buffer
`timescale 1ns/10ps
`include "sepr_cfg.svh"
module sepr_host import sepr_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // two-wire bus
  sepr_if.host BUS,
  // command
  input wire logic CMD_VALID,
  input wire logic [1:0] CMD_OP,
  input wire logic [2:0] CMD_SEL,
  input wire logic [7:0] CMD_WADDR,
  input wire logic [7:0] CMD_LEN,
  output logic CMD_READY,
  output logic NO_ACK,
  // read data stream
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  input wire logic RD_READY
);
  sepr_host_t r;
  sepr_host_t n;
  logic tick;
  logic stall;
  logic push;
  logic pop;
  logic bit_end;

  always_comb begin
    n = r;
    n.s1 = BUS.sda;
    n.s2 = r.s1;
    push = 1'b0;
    // stretch the ack clock high before a new byte while the buffer is full
    stall = r.st == HS_RX && r.cnt == 4'h0 && r.q == 2'h0 && r.head_v && r.tail_v;
    tick = r.div == `SEPR_QTR_LAST && !stall;
    bit_end = tick && r.q == `SEPR_Q_LAST;
    if (r.st != HS_IDLE && !stall) begin
      n.div = tick ? 8'h00 : r.div + `SEPR_DIV_STEP;
    end
    if (tick) begin
      n.q = r.q + `SEPR_Q_STEP;
    end
    unique case (r.st)
      HS_IDLE: begin
        if (CMD_VALID && r.cmd_ready) begin
          n.op = sepr_op_t'(CMD_OP);
          n.sel = CMD_SEL;
          n.waddr = CMD_WADDR;
          n.len = CMD_LEN;
          n.nack = 1'b0;
          n.cmd_ready = 1'b0;
          n.seq = (CMD_OP == OP_CUR) ? 3'h3 : 3'h0;
          n.st = HS_START;
          n.q = 2'h0;
          n.div = 8'h00;
        end
      end
      HS_START: begin
        // scl low first, so a repeated start can follow an ack held low
        if (tick) begin
          unique case (r.q)
            2'h0: n.scl = 1'b0;
            2'h1: n.oe = 1'b0;
            2'h2: n.scl = 1'b1;
            default: n.oe = 1'b1;
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          unique case (r.q)
            2'h0: n.scl = 1'b0;
            2'h1: n.oe = 1'b1;
            2'h2: n.scl = 1'b1;
            default: n.oe = 1'b0;
          endcase
        end
      end
      HS_TX, HS_RX, HS_DUMMY: begin
        if (tick) begin
          unique case (r.q)
            2'h0: n.scl = 1'b0;
            2'h1: begin
              if (r.st == HS_TX) begin
                n.oe = (r.cnt < `SEPR_BYTE_BITS) ? ~r.sh[7] : 1'b0;
              end else if (r.st == HS_RX) begin
                // ack keeps the device sending, nack on the last byte
                n.oe = (r.cnt == `SEPR_BYTE_BITS) ? (r.len != `SEPR_LEN_LAST) : 1'b0;
              end else begin
                n.oe = 1'b0; // recovery clocks keep sda high
              end
            end
            2'h2: n.scl = 1'b1;
            default: begin
              n.cnt = r.cnt + `SEPR_CNT_STEP;
              if (r.st == HS_TX) begin
                n.sh = {r.sh[6:0], 1'b0};
              end else if (r.cnt < `SEPR_BYTE_BITS) begin
                n.sh = {r.sh[6:0], r.s2};
              end
              push = r.st == HS_RX && r.cnt == `SEPR_LAST_DATA;
            end
          endcase
        end
      end
      default: begin
        n.st = HS_IDLE;
      end
    endcase
    // element complete: pick the next one of the command
    if (bit_end) begin
      n.cnt = (r.st == HS_TX || r.st == HS_RX || r.st == HS_DUMMY) ? r.cnt + `SEPR_CNT_STEP : 4'h0;
      if (r.st == HS_STOP) begin
        n.st = HS_IDLE;
        n.cmd_ready = 1'b1;
      end else if (r.st == HS_TX && r.cnt == `SEPR_BYTE_BITS && r.s2) begin
        n.nack = 1'b1; // missing ack ends the command
        n.st = HS_STOP;
      end else if (r.st == HS_RX && r.cnt == `SEPR_BYTE_BITS) begin
        n.cnt = 4'h0;
        n.len = r.len - `SEPR_LEN_STEP;
        // stop only once our nack slot is over, never mid output
        n.st = (r.len == `SEPR_LEN_LAST) ? HS_STOP : HS_RX;
      end else if (r.st == HS_DUMMY && r.cnt == `SEPR_DUMMY_LAST) begin
        n.seq = r.seq + `SEPR_SEQ_STEP;
        n.st = HS_START; // start after the nine clocks, not more clocks
      end else if (r.st == HS_START || (r.st == HS_TX && r.cnt == `SEPR_BYTE_BITS)) begin
        n.seq = r.seq + `SEPR_SEQ_STEP;
        n.cnt = 4'h0;
        if (r.op == OP_REC) begin
          // start, nine clocks, start, stop
          n.st = (r.seq == 3'h0) ? HS_DUMMY : HS_STOP;
        end else begin
          unique case (r.seq)
            3'h0: begin
              n.sh = {`SEPR_DEV_CODE, r.sel, 1'b0}; // dummy write address
              n.st = HS_TX;
            end
            3'h1: begin
              n.sh = r.waddr;
              n.st = HS_TX;
            end
            3'h2: n.st = HS_START; // repeated start before the read
            3'h3: begin
              n.sh = {`SEPR_DEV_CODE, r.sel, 1'b1};
              n.st = HS_TX;
            end
            default: n.st = HS_RX; // address acked: read straight away
          endcase
        end
      end
    end
    // two-entry read buffer, head is the output register
    pop = r.head_v && RD_READY;
    if (pop) begin
      n.head = r.tail;
      n.head_v = r.tail_v;
      n.tail_v = 1'b0;
    end
    if (push) begin
      if (!n.head_v) begin
        n.head = n.sh;
        n.head_v = 1'b1;
      end else begin
        n.tail = n.sh;
        n.tail_v = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      r <= '0;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.st <= HS_IDLE;
      r.scl <= 1'b1;
      r.cmd_ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign BUS.scl = r.scl;
  assign BUS.sda_host_oe = r.oe;
  assign BUS.sda_host_out = `SEPR_LOW;
  assign CMD_READY = r.cmd_ready;
  assign NO_ACK = r.nack;
  assign RD_DATA = r.head;
  assign RD_VALID = r.head_v;
endmodule // sepr_host

// ---- rtl/sepr_if.sv ----
// two-wire bus between the eeprom end and the master end
`timescale 1ns/10ps
interface sepr_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda;
  // open-drain wired-and, pulled high when nobody drives low
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));
  modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe);
  modport host (output scl, output sda_host_out, output sda_host_oe, input sda);
endinterface

// ---- rtl/sepr_pkg.sv ----
// types shared by both ends of the serial eeprom link
package sepr_pkg;
  typedef enum logic [7:0] {
    DS_INIT = 8'h01, DS_IDLE = 8'h02, DS_RX = 8'h04, DS_ACK = 8'h08,
    DS_TX = 8'h10, DS_MACK = 8'h20, DS_WAIT = 8'h40, DS_BUSY = 8'h80
  } sepr_dst_t;
  typedef enum logic [2:0] {BK_DEV = 3'h1, BK_WORD = 3'h2, BK_DATA = 3'h4} sepr_kind_t;
  typedef enum logic [5:0] {
    HS_IDLE = 6'h01, HS_START = 6'h02, HS_TX = 6'h04, HS_RX = 6'h08,
    HS_STOP = 6'h10, HS_DUMMY = 6'h20
  } sepr_hst_t;
  typedef enum logic [1:0] {OP_CUR = 2'h0, OP_RAND = 2'h1, OP_REC = 2'h2} sepr_op_t;
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic s3_scl;
    logic s3_sda;
    sepr_dst_t st;
    sepr_kind_t kind;
    logic rw;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] pend_addr;
    logic [7:0] pend_data;
    logic pend;
    logic [15:0] tmr;
    logic oe;
    logic [255:0][7:0] mem;
  } sepr_dev_t;
  typedef struct packed {
    logic s1;
    logic s2;
    sepr_hst_t st;
    sepr_op_t op;
    logic [2:0] seq;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] len;
    logic [7:0] waddr;
    logic [2:0] sel;
    logic scl;
    logic oe;
    logic cmd_ready;
    logic nack;
    logic [7:0] head;
    logic head_v;
    logic [7:0] tail;
    logic tail_v;
  } sepr_host_t;
endpackage
